// ---- rtl/input_sync.sv ----
// Two-stage synchroniser for the asynchronous control lines
module input_sync
  import safety_inputs_pkg::*;
#(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Lines
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  // First stage feeds only the second stage
  always_comb begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.s2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sync_two_stage: assert property (
    ce ##1 ce |=> q == $past(d, 2))
    else $error("synchroniser latency is not two stages");

endmodule : input_sync

// ---- rtl/safety_inputs.sv ----
// Node address, emergency stop, charge permission and chain fault logic
module safety_inputs
  import safety_inputs_pkg::*;
#(
  parameter int DIS_HOLD_CYCLES = DISCHARGE_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Wishbone classic slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Address straps, high when tied to the isolated return
  input  wire logic                node_addr_bit0,
  input  wire logic                node_addr_bit1,
  input  wire logic                node_addr_bit2,
  input  wire logic                node_addr_bit3,
  input  wire logic                node_addr_bit4,
  // Control lines
  input  wire logic                emergency_stop_in,
  input  wire logic                charge_permit_in,
  // Shared open-drain fault line, low means fault
  input  wire logic                chain_fault_line_in,
  output logic                     chain_fault_line_out,
  output logic                     chain_fault_line_oe,
  // Power stage control and status
  output logic                     power_enable,
  output logic                     fast_discharge_en,
  output logic                     fault,
  output logic      [CAN_ID_W-1:0] can_node_id,
  output logic                     node_addr_valid,
  output logic                     irq
);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  line_bits_t           lines;
  logic [2:0]           lines_raw;
  logic [2:0]           lines_sync;
  logic [ADDR_BITS-1:0] node_addr;
  logic [ADDR_BITS-1:0] straps;

  assign straps = {node_addr_bit4, node_addr_bit3, node_addr_bit2,
                   node_addr_bit1, node_addr_bit0};
  // Floating emergency input arrives here as a high level
  assign lines_raw = {emergency_stop_in, charge_permit_in,
                      ~chain_fault_line_in};
  assign lines     = line_bits_t'(lines_sync);

  input_sync #(
    .W (3)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   (lines_raw),
    .q   (lines_sync)
  );

  strap_capture u_strap (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .straps    (straps),
    .node_addr (node_addr),
    .can_id    (can_node_id),
    .valid     (node_addr_valid)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  main_state_t r;
  main_state_t n;

  logic             access;
  logic             wr_ctrl;
  logic             rd_irq;
  logic             start_cmd;
  logic             stop_cmd;
  logic             ack_cmd;
  logic             permit_block;
  logic             chain_seen;
  logic [IRQ_W-1:0] ev;
  logic [31:0]      status_word;

  always_comb begin
    status_word = '0;
    status_word[STAT_CAN_ID_LSB +: CAN_ID_W] = can_node_id;
    status_word[STAT_ADDR_VALID] = node_addr_valid;
    status_word[STAT_RUNNING]    = r.st == ST_RUNNING;
    status_word[STAT_FAULT]      = r.st == ST_FAULT;
    status_word[STAT_ESTOP]      = r.st == ST_ESTOP;
    status_word[STAT_DISCHARGE]  = r.discharge;
    status_word[STAT_ESTOP_LINE] = lines.estop;
    status_word[STAT_PERMIT]     = lines.permit;
    status_word[STAT_CHAIN]      = lines.chain_low;
    status_word[STAT_PERMIT_EN]  = r.permit_en;
  end

  // ----------------------------------------------------------------
  // Bus decode and next state
  // ----------------------------------------------------------------
  always_comb begin
    n      = r;
    ev     = '0;
    access = wb_cyc_i & wb_stb_i & ~r.ack;
    wr_ctrl = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
    rd_irq  = access & ~wb_we_i & (wb_adr_i == REG_IRQ_STAT);
    start_cmd = wr_ctrl & wb_dat_i[CTRL_START];
    stop_cmd  = wr_ctrl & wb_dat_i[CTRL_STOP];
    ack_cmd   = wr_ctrl & wb_dat_i[CTRL_FAULT_ACK];
    permit_block = r.permit_en & ~lines.permit;
    // Our own drive is excluded so a local fault is not seen twice
    chain_seen   = lines.chain_low & ~r.chain_drive;

    n.ack   = access;
    n.rdata = '0;
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: begin
          n.rdata[CTRL_PERMIT_EN] = r.permit_en;
        end
        REG_STATUS: begin
          n.rdata = status_word;
        end
        REG_IRQ_STAT: begin
          n.rdata[IRQ_W-1:0] = r.irq_stat;
        end
        REG_IRQ_MASK: begin
          n.rdata[IRQ_W-1:0] = r.irq_mask;
        end
        default: begin
          n.rdata = '0;
        end
      endcase
    end
    if (wr_ctrl) begin
      n.permit_en = wb_dat_i[CTRL_PERMIT_EN];
    end
    if (access && wb_we_i && wb_sel_i[0] &&
        wb_adr_i == REG_IRQ_MASK) begin
      n.irq_mask = wb_dat_i[IRQ_W-1:0];
    end

    n.chain_prev = chain_seen;
    if (chain_seen && !r.chain_prev) begin
      ev[IRQ_CHAIN] = 1'b1;
    end

    // Emergency stop overrides every state and every command
    if (lines.estop) begin
      n.st      = ST_ESTOP;
      n.dis_cnt = DIS_CNT_W'(DIS_HOLD_CYCLES);
      if (r.st != ST_ESTOP) begin
        ev[IRQ_ESTOP] = 1'b1;
      end
    end else begin
      case (r.st)
        ST_STANDBY: begin
          if (start_cmd) begin
            if (permit_block) begin
              n.st = ST_FAULT;
              ev[IRQ_REFUSED] = 1'b1;
            end else if (chain_seen) begin
              ev[IRQ_REFUSED] = 1'b1;
            end else begin
              n.st = ST_RUNNING;
            end
          end
        end
        ST_RUNNING: begin
          if (stop_cmd) begin
            n.st = ST_STANDBY;
          end else if (permit_block) begin
            n.st = ST_STANDBY;
            ev[IRQ_PERMIT_STOP] = 1'b1;
          end else if (chain_seen) begin
            n.st = ST_STANDBY;
          end
        end
        ST_FAULT: begin
          if (ack_cmd) begin
            n.st = ST_STANDBY;
          end
        end
        ST_ESTOP: begin
          // Discharge stays on for the full hold after the line clears
          if (r.dis_cnt == '0) begin
            n.st = ST_STANDBY;
          end else begin
            n.dis_cnt = r.dis_cnt - 1'b1;
          end
        end
        default: begin
          n.st = ST_STANDBY;
        end
      endcase
    end

    n.power_en    = n.st == ST_RUNNING;
    n.discharge   = n.st == ST_ESTOP;
    n.fault_out   = n.st == ST_FAULT;
    n.chain_drive = n.st == ST_FAULT;

    // A read clears, but an event in the same cycle survives
    n.irq_stat = (r.irq_stat & ~{IRQ_W{rd_irq}}) | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_dat_o             = r.rdata;
  assign wb_ack_o             = r.ack;
  assign power_enable         = r.power_en;
  assign fast_discharge_en    = r.discharge;
  assign fault                = r.fault_out;
  assign chain_fault_line_oe  = r.chain_drive;
  assign chain_fault_line_out = 1'b0;
  assign irq                  = r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_estop_power_off: assert property (
    ce && lines.estop |=> !power_enable && fast_discharge_en)
    else $error("power still on after emergency stop");

  a_float_estop: assert property (
    (ce && emergency_stop_in) [*3] |=> r.st == ST_ESTOP)
    else $error("floating emergency line did not stop the unit");

  a_discharge_load: assert property (
    $rose(r.st == ST_ESTOP) |->
      r.dis_cnt == DIS_CNT_W'(DIS_HOLD_CYCLES) && fast_discharge_en)
    else $error("discharge hold not loaded on emergency stop");

  a_discharge_end: assert property (
    ce && r.st == ST_ESTOP && !lines.estop && r.dis_cnt == '0
      |=> r.st == ST_STANDBY && !fast_discharge_en)
    else $error("discharge did not end after its hold");

  a_stop_either: assert property (
    ce && r.st == ST_RUNNING && !lines.estop && (stop_cmd || permit_block)
      |=> r.st == ST_STANDBY && !power_enable)
    else $error("stop request did not stop operation");

  a_permit_off_reset: assert property (
    $fell(rst) |-> !r.permit_en && !power_enable)
    else $error("charge permission enabled after reset");

  a_permit_forbid: assert property (
    ce && r.permit_en && !lines.permit |=> !power_enable)
    else $error("power output while permission forbids it");

  a_refuse_start: assert property (
    ce && r.st == ST_STANDBY && start_cmd && permit_block && !lines.estop
      |=> r.st == ST_FAULT && fault && r.irq_stat[IRQ_REFUSED])
    else $error("forbidden start not refused with fault");

  a_start_on_cmd: assert property (
    $rose(power_enable) |-> $past(start_cmd) && $past(ce))
    else $error("power started without a start command");

  a_chain_stop: assert property (
    ce && chain_seen && r.st == ST_RUNNING |=> !power_enable)
    else $error("chain fault did not stop this unit");

  a_node_id_out: assert property (
    node_addr_valid |-> can_node_id == can_id_of(node_addr))
    else $error("node identifier does not follow captured address");

  a_chain_drive: assert property (
    r.st == ST_FAULT |-> chain_fault_line_oe && !chain_fault_line_out)
    else $error("faulted unit is not pulling the chain line");

  c_estop_seen:    cover property ($rose(r.st == ST_ESTOP));
  c_running:       cover property ($rose(power_enable));
  c_refused_start: cover property (ce && start_cmd && permit_block);
  c_chain_stop:    cover property (ce && chain_seen && power_enable);

endmodule : safety_inputs

// ---- rtl/safety_inputs_pkg.sv ----
// Constants, types and helpers shared by the safety input block
package safety_inputs_pkg;

  // ----------------------------------------------------------------
  // Node address
  // ----------------------------------------------------------------
  localparam int        ADDR_BITS   = 5;
  localparam int        CAN_ID_W    = 7;
  localparam logic [6:0] CAN_ID_BASE = 7'h50;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int         ADR_W        = 4;
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h8;
  localparam logic [3:0] REG_IRQ_MASK = 4'hC;

  // Control register bits; start, stop and ack are write-only pulses
  localparam int CTRL_PERMIT_EN = 0;
  localparam int CTRL_START     = 1;
  localparam int CTRL_STOP      = 2;
  localparam int CTRL_FAULT_ACK = 3;

  // Status register fields
  localparam int STAT_CAN_ID_LSB = 0;
  localparam int STAT_ADDR_VALID = 7;
  localparam int STAT_RUNNING    = 8;
  localparam int STAT_FAULT      = 9;
  localparam int STAT_ESTOP      = 10;
  localparam int STAT_DISCHARGE  = 11;
  localparam int STAT_ESTOP_LINE = 12;
  localparam int STAT_PERMIT     = 13;
  localparam int STAT_CHAIN      = 14;
  localparam int STAT_PERMIT_EN  = 15;

  // Interrupt status and mask bits
  localparam int IRQ_W           = 4;
  localparam int IRQ_ESTOP       = 0;
  localparam int IRQ_REFUSED     = 1;
  localparam int IRQ_CHAIN       = 2;
  localparam int IRQ_PERMIT_STOP = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 10_000_000;
  localparam int DISCHARGE_TIME_MS = 1000;
  localparam int DISCHARGE_CYCLES  = (CLK_HZ / 1000) * DISCHARGE_TIME_MS;
  localparam int DIS_CNT_W         = 24;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_RUNNING,
    ST_FAULT,
    ST_ESTOP
  } run_state_t;

  typedef struct packed {
    logic estop;
    logic permit;
    logic chain_low;
  } line_bits_t;

  typedef struct packed {
    run_state_t           st;
    logic                 permit_en;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [DIS_CNT_W-1:0] dis_cnt;
    logic                 chain_prev;
    logic                 discharge;
    logic                 power_en;
    logic                 fault_out;
    logic                 chain_drive;
    logic                 irq;
    logic                 ack;
    logic [31:0]          rdata;
  } main_state_t;

  function automatic logic [6:0] can_id_of(input logic [4:0] addr);
    can_id_of = CAN_ID_BASE + {2'h0, addr};
  endfunction : can_id_of

endpackage : safety_inputs_pkg

// ---- rtl/strap_capture.sv ----
// Boot-time capture of the strap address and its CAN identifier
module strap_capture
  import safety_inputs_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Straps, bit 0 least significant
  input  wire logic [ADDR_BITS-1:0] straps,
  // Result
  output logic      [ADDR_BITS-1:0] node_addr,
  output logic      [CAN_ID_W-1:0]  can_id,
  output logic                      valid
);

  typedef struct packed {
    logic                 valid;
    logic [ADDR_BITS-1:0] addr;
    logic [CAN_ID_W-1:0]  id;
  } strap_state_t;

  strap_state_t r;
  strap_state_t n;

  // Straps move only with hands on the connector, so one sample is kept
  always_comb begin
    n = r;
    if (!r.valid) begin
      n.valid = 1'b1;
      n.addr  = straps;
      n.id    = can_id_of(straps);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign node_addr = r.addr;
  assign can_id    = r.id;
  assign valid     = r.valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_strap_sampled: assert property (
    !r.valid && ce |=> r.valid && r.addr == $past(straps))
    else $error("strap value not captured as weighted bits");

  a_addr_held: assert property (
    r.valid |=> $stable(r.addr) && $stable(r.id))
    else $error("captured node address changed before reboot");

  a_can_id_map: assert property (
    r.valid |-> r.id == can_id_of(r.addr))
    else $error("CAN identifier is not base plus strap value");

endmodule : strap_capture

// ---- verif/far_side_model.sv ----
// Far-side model: system controller and one chained sibling unit
module far_side_model (
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic estop_req,
  input  wire logic permit_req,
  input  wire logic sibling_fault,
  // Open-drain drive of the unit under test
  input  wire logic chain_out,
  input  wire logic chain_oe,
  // Lines toward the unit
  output logic      estop_line,
  output logic      permit_line,
  output logic      chain_line
);
  timeunit 1ns;
  timeprecision 1ns;

  logic sib_pull;

  initial begin
    estop_line  = 1'b0;
    permit_line = 1'b0;
    sib_pull    = 1'b0;
  end

  // ----------------------------------------------------------------
  // Controller and sibling
  // ----------------------------------------------------------------
  // A floating stop line reads high; the controller holds it low
  always @(posedge clk) begin
    estop_line  <= estop_req;
    permit_line <= permit_req;
    sib_pull    <= sibling_fault;
  end

  // Pulled-up shared line; the controller never drives it
  assign chain_line = ((chain_oe && !chain_out) || sib_pull) ? 1'b0 : 1'b1;
endmodule : far_side_model

// ---- verif/tb_safety_inputs.sv ----
// Self-checking bench for the safety input block
module tb_safety_inputs
  import safety_inputs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HOLD = 20;

  logic                clk;
  logic                rst;
  logic                ce;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [ADR_W-1:0]    adr;
  logic [31:0]         wdat;
  logic [31:0]         rdat;
  logic [31:0]         q;
  logic                wb_ack;
  logic [4:0]          straps;
  logic                estop_req;
  logic                permit_req;
  logic                sib_fault;
  logic                estop_l;
  logic                permit_l;
  logic                chain_l;
  logic                ch_out;
  logic                ch_oe;
  logic                pwr;
  logic                dis;
  logic                flt;
  logic                addr_ok;
  logic                irq_o;
  logic [CAN_ID_W-1:0] node_id;
  int                  bad_count;
  int                  checks_done;

  safety_inputs #(.DIS_HOLD_CYCLES(HOLD)) u_dut (
    .clk(clk), .rst(rst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wb_ack),
    .node_addr_bit0(straps[0]), .node_addr_bit1(straps[1]),
    .node_addr_bit2(straps[2]), .node_addr_bit3(straps[3]),
    .node_addr_bit4(straps[4]),
    .emergency_stop_in(estop_l), .charge_permit_in(permit_l),
    .chain_fault_line_in(chain_l), .chain_fault_line_out(ch_out),
    .chain_fault_line_oe(ch_oe), .power_enable(pwr),
    .fast_discharge_en(dis), .fault(flt), .can_node_id(node_id),
    .node_addr_valid(addr_ok), .irq(irq_o)
  );

  far_side_model u_far (
    .clk(clk), .estop_req(estop_req), .permit_req(permit_req),
    .sibling_fault(sib_fault), .chain_out(ch_out), .chain_oe(ch_oe),
    .estop_line(estop_l), .permit_line(permit_l), .chain_line(chain_l)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Classic single cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk("bus ack", 32'h1, 32'(n < 100));
  endtask : wb

  task automatic boot(input logic [4:0] s);
    @(posedge clk);
    rst        <= 1'b1;
    straps     <= s;
    estop_req  <= 1'b0;
    permit_req <= 1'b0;
    sib_fault  <= 1'b0;
    tick(4);
    rst <= 1'b0;
    tick(4);
  endtask : boot

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_address;
    for (int i = 0; i < 32; i++) begin
      boot(i[4:0]);
      chk("can_node_id", 32'h50 + 32'(i), 32'(node_id));
      chk("addr valid", 32'h1, 32'(addr_ok));
      straps <= ~i[4:0];
      tick(3);
      chk("held id", 32'h50 + 32'(i), 32'(node_id));
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0000_00EF, q);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    wb(1'b0, REG_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h0, q);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped read", 32'h0, q);
  endtask : t_address

  task automatic t_permit;
    boot(5'h00);
    wb(1'b1, REG_CTRL, 32'h2);
    tick(1);
    chk("start ungated", 32'h1, 32'(pwr));
    wb(1'b1, REG_CTRL, 32'h4);
    tick(1);
    chk("bus stop", 32'h0, 32'(pwr));
    wb(1'b1, REG_CTRL, 32'h1);
    permit_req <= 1'b1;
    tick(4);
    wb(1'b1, REG_CTRL, 32'h3);
    tick(1);
    chk("permitted start", 32'h1, 32'(pwr));
    permit_req <= 1'b0;
    tick(6);
    chk("permit stop", 32'h0, 32'(pwr));
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("permit event", 32'h8, q);
    wb(1'b1, REG_CTRL, 32'h3);
    tick(1);
    chk("refused start", 32'h0, 32'(pwr));
    chk("fault", 32'h1, 32'(flt));
    chk("chain drive", 32'h1, 32'(ch_oe));
    chk("chain level", 32'h0, 32'(chain_l));
    chk("chain out", 32'h0, 32'(ch_out));
    // Enable low must freeze the latched fault
    ce <= 1'b0;
    tick(5);
    chk("frozen fault", 32'h1, 32'(flt));
    ce <= 1'b1;
    tick(1);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("refuse event", 32'h2, q);
    wb(1'b1, REG_CTRL, 32'h9);
    tick(1);
    chk("fault cleared", 32'h0, 32'(flt));
  endtask : t_permit

  task automatic t_chain;
    boot(5'h01);
    wb(1'b1, REG_CTRL, 32'h2);
    tick(1);
    chk("running", 32'h1, 32'(pwr));
    sib_fault <= 1'b1;
    tick(6);
    chk("sibling stop", 32'h0, 32'(pwr));
    wb(1'b1, REG_CTRL, 32'h2);
    tick(1);
    chk("start on chain", 32'h0, 32'(pwr));
    chk("masked irq", 32'h0, 32'(irq_o));
    sib_fault <= 1'b0;
    tick(6);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("chain events", 32'h6, q);
  endtask : t_chain

  task automatic t_estop;
    boot(5'h02);
    wb(1'b1, REG_IRQ_MASK, 32'hF);
    wb(1'b1, REG_CTRL, 32'h2);
    tick(1);
    estop_req <= 1'b1;
    tick(3);
    // Two sync stages must delay the reaction
    chk("estop early", 32'h1, 32'(pwr));
    tick(2);
    chk("estop power", 32'h0, 32'(pwr));
    chk("discharge on", 32'h1, 32'(dis));
    chk("irq raised", 32'h1, 32'(irq_o));
    wb(1'b1, REG_CTRL, 32'h2);
    tick(1);
    chk("start in estop", 32'h0, 32'(pwr));
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("estop event", 32'h1, q);
    tick(2);
    chk("irq cleared", 32'h0, 32'(irq_o));
    estop_req <= 1'b0;
    tick(15);
    chk("discharge held", 32'h1, 32'(dis));
    tick(30);
    chk("discharge off", 32'h0, 32'(dis));
  endtask : t_estop

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Clock, main sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    bad_count   = 0;
    checks_done = 0;
    rst         = 1'b1;
    ce          = 1'b1;
    cyc         = 1'b0;
    stb         = 1'b0;
    we          = 1'b0;
    adr         = '0;
    wdat        = 32'h0;
    straps      = 5'h00;
    estop_req   = 1'b0;
    permit_req  = 1'b0;
    sib_fault   = 1'b0;
    tick(4);
    rst <= 1'b0;
    t_address();
    t_permit();
    t_chain();
    t_estop();
    report_and_stop();
  end

  // The whole run needs about six hundred cycles
  initial begin
    tick(30000);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_safety_inputs
